// ---- include/scmc_pkg.sv ----
package scmc_pkg;

    // Register addresses on the plain register port
    localparam logic [7:0] SCMC_SYS_CLOCK_CONTROL_ADDR   = 8'h00;
    localparam logic [7:0] SCMC_FAST_OSC_CONTROL_ADDR    = 8'h01;

    // Field positions in system_clock_control
    localparam int         SCMC_SEL_MSB                  = 7;
    localparam int         SCMC_SEL_LSB                  = 5;
    localparam int         SCMC_FAST_IDLE_BIT            = 1;
    localparam int         SCMC_SLOW_IDLE_BIT            = 0;

    // Field positions in fast_oscillator_control
    localparam int         SCMC_STABLE_BIT               = 1;
    localparam int         SCMC_ENABLE_BIT               = 0;

    // Select code that picks the sub clock
    localparam logic [2:0] SCMC_SEL_SUB                  = 3'h7;

    // Values after reset
    localparam logic [2:0] SCMC_SEL_RST                  = 3'h0;
    localparam logic       SCMC_IDLE_KEEP_RST            = 1'b0;
    localparam logic       SCMC_FAST_EN_RST              = 1'b1;
    localparam logic       SCMC_STABLE_RST               = 1'b0;
    localparam logic       SCMC_FLAG_RST                 = 1'b0;

    // Fast oscillator ticks counted before it is taken as stable
    localparam logic [15:0] SCMC_FAST_STABLE_TICKS       = 16'h0400;

    // Width of the fast clock prescaler, giving division up to 64
    localparam int         SCMC_PRE_W                    = 6;

    // Operating modes, one-hot
    typedef enum logic [5:0] {
        MD_FAST  = 6'b000001,
        MD_SLOW  = 6'b000010,
        MD_IDLE_SLOW_ONLY = 6'b000100,
        MD_IDLE_BOTH_CLOCKS = 6'b001000,
        MD_IDLE_FAST_ONLY = 6'b010000,
        MD_SLEEP = 6'b100000
    } scmc_mode_e;

endpackage

// ---- design/scmc_top.sv ----
`timescale 1ns/1ps
// How it works
// R01 - Select codes 0-6 divide fast clock, 7 sub
// R02 - Fast clock from fast RC, sub from slow
// R03 - FAST mode: CPU on divided fast clock, all running
// R04 - SLOW mode keeps fast oscillator per enable bit
// R05 - Halt with both keeps low: SLEEP, clocks stopped
// R06 - Slow-only idle: sub on, system clock if 111
// R07 - Both-keeps idle: fast, sub, system clocks on
// R08 - Fast-only idle: fast on, system clock if 0-6
// R09 - Writing 111 switches to SLOW once slow stable
// R10 - Fast code in SLOW restarts, waits stable oscillator
// R11 - Enabling fast oscillator clears then sets stable flag
// R12 - Enable bit resets to 1, stable flag to 0
// R13 - Unimplemented register bits read as zero
// R14 - Power-down sets down flag, clears timeout flag
// R15 - Source change only at boundary, glitch free
// R16 - Software polls stable flag after re-enabling oscillator
module scmc_top
    import scmc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       halt_exec,
    input  wire logic       wake_event,
    input  wire logic       clr_wdt_exec,
    input  wire logic       wdt_timeout,
    input  wire logic       wdt_enable,
    input  wire logic       fast_osc_tick,
    input  wire logic       slow_osc_tick,
    input  wire logic       slow_osc_stable,
    output logic            fast_osc_run,
    output logic            slow_osc_run,
    output logic            cpu_run,
    output logic            sys_clk_tick,
    output logic            sys_clk_on,
    output logic            sys_on_slow,
    output logic            fast_clk_on,
    output logic            sub_clk_on,
    output logic      [6:0] fast_div_tick,
    output logic            power_down_flag,
    output logic            watchdog_timeout_flag,
    output logic      [5:0] op_mode
);

    // True for the codes that pick a fast clock division
    function automatic logic is_fast_code(input logic [2:0] code);
        return code != SCMC_SEL_SUB;
    endfunction

    // True when the prescaler sits at the last count of a divide-by-2^k period
    function automatic logic div_hit(input logic [SCMC_PRE_W-1:0] pre, input int k);
        logic [SCMC_PRE_W-1:0] mask;
        mask = ~({SCMC_PRE_W{1'b1}} << k);
        return (pre & mask) == mask;
    endfunction

    logic [2:0]            sel_r;
    logic                  fast_keep_r;
    logic                  slow_keep_r;
    logic                  fast_en_r;
    logic                  stable_r;
    logic [15:0]           stab_cnt_r;
    logic [SCMC_PRE_W-1:0] pre_r;
    logic                  act_slow_r;
    logic [2:0]            act_div_r;
    scmc_mode_e            mode_r;
    logic                  pd_r;
    logic                  to_r;
    logic [7:0]            rdata_r;

    logic                  running;
    logic                  wr_scc;
    logic                  wr_fosc;
    logic                  en_rise;
    logic                  fast_run_w;
    logic                  restart;
    logic                  fast_tick_ok;
    logic                  src_tick;
    logic                  sys_on_w;
    logic                  sub_on_w;
    logic                  halt_go;
    logic                  to_slow;
    logic                  to_fast;
    logic                  div_change;

    assign running  = (mode_r == MD_FAST) || (mode_r == MD_SLOW);
    assign wr_scc   = reg_wr && (reg_addr == SCMC_SYS_CLOCK_CONTROL_ADDR);
    assign wr_fosc  = reg_wr && (reg_addr == SCMC_FAST_OSC_CONTROL_ADDR);
    assign en_rise  = wr_fosc && reg_wdata[SCMC_ENABLE_BIT] && !fast_en_r;
    assign halt_go  = clk_en && halt_exec && running;

    // Fast oscillator demand: needed while running from it or heading to it,
    // otherwise the enable bit decides; idle modes follow the keep bits
    always_comb begin
        fast_run_w = 1'b0;
        unique case (mode_r)
            MD_FAST:  fast_run_w = 1'b1;                                              // R03
            MD_SLOW:  fast_run_w = fast_en_r || is_fast_code(sel_r);                  // R04 R10
            MD_IDLE_BOTH_CLOCKS: fast_run_w = 1'b1;                                              // R07
            MD_IDLE_FAST_ONLY: fast_run_w = 1'b1;                                              // R08
            default:  fast_run_w = 1'b0;                                              // R05 R06
        endcase
    end

    // Sub clock and system clock gating per operating mode
    always_comb begin
        sub_on_w = 1'b0;
        sys_on_w = 1'b0;
        unique case (mode_r)
            MD_FAST, MD_SLOW: begin
                sub_on_w = 1'b1;                                                      // R03
                sys_on_w = 1'b1;
            end
            MD_IDLE_SLOW_ONLY: begin
                sub_on_w = 1'b1;                                                      // R06
                sys_on_w = !is_fast_code(sel_r);
            end
            MD_IDLE_BOTH_CLOCKS: begin
                sub_on_w = 1'b1;                                                      // R07
                sys_on_w = 1'b1;
            end
            MD_IDLE_FAST_ONLY: begin
                sub_on_w = 1'b0;                                                      // R08
                sys_on_w = is_fast_code(sel_r);
            end
            default: begin
                sub_on_w = 1'b0;                                                      // R05
                sys_on_w = 1'b0;
            end
        endcase
    end

    // Stability is re-proved whenever the oscillator stops or software re-enables it
    assign restart      = !fast_run_w || (clk_en && en_rise);
    assign fast_tick_ok = fast_osc_tick && fast_run_w && stable_r;                    // R02

    // Every fast division taps one prescaler; tap 6 marks a common boundary
    generate
        for (genvar k = 0; k < 7; k++) begin : g_div
            assign fast_div_tick[k] = fast_tick_ok && div_hit(pre_r, k);              // R01
        end
    endgenerate

    // Selected source: only one tick path is ever passed, so no runt edges
    assign src_tick = act_slow_r ? slow_osc_tick : fast_div_tick[act_div_r];          // R01 R02 R15

    // Switch requests, each committed only at a clean boundary of the old source
    assign to_slow    = running && !is_fast_code(sel_r) && !act_slow_r && slow_osc_stable
                        && (src_tick || !stable_r);                                   // R09 R15
    assign to_fast    = running && is_fast_code(sel_r) && act_slow_r && stable_r
                        && slow_osc_tick;                                             // R10 R15
    assign div_change = running && is_fast_code(sel_r) && !act_slow_r
                        && (act_div_r != sel_r) && fast_div_tick[6];                  // R15

    // Software-written control fields
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_r       <= SCMC_SEL_RST;
            fast_keep_r <= SCMC_IDLE_KEEP_RST;
            slow_keep_r <= SCMC_IDLE_KEEP_RST;
            fast_en_r   <= SCMC_FAST_EN_RST;                                          // R12
        end else if (clk_en) begin
            if (wr_scc) begin
                sel_r       <= reg_wdata[SCMC_SEL_MSB:SCMC_SEL_LSB];
                fast_keep_r <= reg_wdata[SCMC_FAST_IDLE_BIT];
                slow_keep_r <= reg_wdata[SCMC_SLOW_IDLE_BIT];
            end
            if (wr_fosc) begin
                fast_en_r <= reg_wdata[SCMC_ENABLE_BIT];                              // R12
            end
        end
    end

    // Stability counter; flag drops on enable and rises after the settle count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stab_cnt_r <= 16'h0000;
            stable_r   <= SCMC_STABLE_RST;                                            // R12
        end else if (clk_en) begin
            if (restart) begin
                stab_cnt_r <= 16'h0000;
                stable_r   <= 1'b0;                                                   // R11
            end else if (fast_osc_tick && !stable_r) begin
                if (stab_cnt_r == SCMC_FAST_STABLE_TICKS - 16'h0001) begin
                    stable_r <= 1'b1;                                                 // R11 R10
                end else begin
                    stab_cnt_r <= stab_cnt_r + 16'h0001;
                end
            end
        end
    end

    // Prescaler runs only on good fast ticks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pre_r <= '0;
        end else if (clk_en && fast_tick_ok) begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // Active source and division; old source held until the new one is ready
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act_slow_r <= 1'b0;
            act_div_r  <= SCMC_SEL_RST;
        end else if (clk_en) begin
            if (to_slow) begin
                act_slow_r <= 1'b1;                                                   // R09
            end else if (to_fast) begin
                act_slow_r <= 1'b0;                                                   // R10
                act_div_r  <= sel_r;
            end else if (div_change) begin
                act_div_r  <= sel_r;                                                  // R01 R15
            end
        end
    end

    // Operating mode; halt picks the low-power mode from the two keep bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_r <= MD_FAST;
        end else if (clk_en) begin
            unique case (mode_r)
                MD_FAST, MD_SLOW: begin
                    if (halt_exec) begin
                        unique case ({fast_keep_r, slow_keep_r})
                            2'b00:   mode_r <= MD_SLEEP;                              // R05
                            2'b01:   mode_r <= MD_IDLE_SLOW_ONLY;                              // R06
                            2'b11:   mode_r <= MD_IDLE_BOTH_CLOCKS;                              // R07
                            default: mode_r <= MD_IDLE_FAST_ONLY;                              // R08
                        endcase
                    end else if (to_slow) begin
                        mode_r <= MD_SLOW;                                            // R09
                    end else if (to_fast) begin
                        mode_r <= MD_FAST;                                            // R10
                    end
                end
                MD_IDLE_SLOW_ONLY, MD_IDLE_BOTH_CLOCKS, MD_IDLE_FAST_ONLY, MD_SLEEP: begin
                    if (wake_event) begin
                        mode_r <= act_slow_r ? MD_SLOW : MD_FAST;
                    end
                end
                default: mode_r <= MD_FAST;
            endcase
        end
    end

    // Status flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pd_r <= SCMC_FLAG_RST;
            to_r <= SCMC_FLAG_RST;
        end else if (clk_en) begin
            if (halt_go) begin
                pd_r <= 1'b1;                                                         // R14
            end else if (clr_wdt_exec) begin
                pd_r <= 1'b0;
            end
            if (wdt_timeout) begin
                to_r <= 1'b1;
            end else if (halt_go) begin
                to_r <= 1'b0;                                                         // R14
            end
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else if (clk_en) begin
            rdata_r <= 8'h00;
            if (reg_rd && reg_addr == SCMC_SYS_CLOCK_CONTROL_ADDR) begin
                rdata_r <= {sel_r, 3'h0, fast_keep_r, slow_keep_r};                   // R13
            end else if (reg_rd && reg_addr == SCMC_FAST_OSC_CONTROL_ADDR) begin
                rdata_r <= {6'h00, stable_r, fast_en_r};                              // R13 R16
            end
        end
    end

    // Outputs
    assign reg_rdata             = rdata_r;
    assign fast_osc_run          = fast_run_w;
    assign slow_osc_run          = (mode_r == MD_SLEEP) ? wdt_enable : 1'b1;          // R05
    assign cpu_run               = running;
    assign sys_clk_on            = sys_on_w;
    assign sys_clk_tick          = src_tick && sys_on_w;
    assign sys_on_slow           = act_slow_r;
    assign fast_clk_on           = fast_run_w && stable_r;
    assign sub_clk_on            = sub_on_w;
    assign power_down_flag       = pd_r;
    assign watchdog_timeout_flag = to_r;
    assign op_mode               = mode_r;

    // Checks of the documented behaviour
    property p_reset_vals;
        @(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> fast_en_r && !stable_r && (sel_r == SCMC_SEL_RST);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // R12
    property p_unimpl;
        @(posedge clk) disable iff (sys_rst)
        clk_en && reg_rd |=> (reg_rdata[4:2] == 3'h0) && ($past(reg_addr) != SCMC_FAST_OSC_CONTROL_ADDR
                             || reg_rdata[7:2] == 6'h00);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero"); // R13
    property p_sleep;
        @(posedge clk) disable iff (sys_rst)
        mode_r == MD_SLEEP |-> !cpu_run && !fast_osc_run && !sub_clk_on && !sys_clk_tick
                               && (slow_osc_run == wdt_enable);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep clocks wrong"); // R05
    property p_idle_slow_only;
        @(posedge clk) disable iff (sys_rst)
        mode_r == MD_IDLE_SLOW_ONLY |-> !cpu_run && !fast_osc_run && sub_clk_on && (sys_clk_on == (sel_r == SCMC_SEL_SUB));
    endproperty
    a_idle_slow_only: assert property (p_idle_slow_only) else $error("slow-only idle clocks wrong"); // R06
    property p_idle_both_clocks;
        @(posedge clk) disable iff (sys_rst)
        mode_r == MD_IDLE_BOTH_CLOCKS |-> !cpu_run && fast_osc_run && sub_clk_on && sys_clk_on;
    endproperty
    a_idle_both_clocks: assert property (p_idle_both_clocks) else $error("both-keeps idle clocks wrong"); // R07
    property p_idle_fast_only;
        @(posedge clk) disable iff (sys_rst)
        mode_r == MD_IDLE_FAST_ONLY |-> !cpu_run && fast_osc_run && !sub_clk_on && (sys_clk_on == (sel_r != SCMC_SEL_SUB));
    endproperty
    a_idle_fast_only: assert property (p_idle_fast_only) else $error("fast-only idle clocks wrong"); // R08
    property p_halt_flags;
        @(posedge clk) disable iff (sys_rst)
        halt_go && !wdt_timeout |=> power_down_flag && !watchdog_timeout_flag && !cpu_run;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("power-down flags wrong"); // R14
    property p_enable_clears;
        @(posedge clk) disable iff (sys_rst)
        clk_en && en_rise |=> !stable_r ##0 (!stable_r)[*1];
    endproperty
    a_enable_clears: assert property (p_enable_clears) else $error("stable flag not cleared"); // R11
    property p_slow_switch;
        @(posedge clk) disable iff (sys_rst)
        $rose(act_slow_r) |-> $past(slow_osc_stable) && $past(sel_r) == SCMC_SEL_SUB && mode_r != MD_FAST;
    endproperty
    a_slow_switch: assert property (p_slow_switch) else $error("slow switch before stable"); // R09
    property p_fast_switch;
        @(posedge clk) disable iff (sys_rst)
        $fell(act_slow_r) |-> $past(stable_r) && mode_r != MD_SLOW && act_div_r == $past(sel_r);
    endproperty
    a_fast_switch: assert property (p_fast_switch) else $error("fast switch before stable"); // R10
    property p_slow_keep;
        @(posedge clk) disable iff (sys_rst)
        mode_r == MD_SLOW && sel_r == SCMC_SEL_SUB |-> fast_osc_run == fast_en_r;
    endproperty
    a_slow_keep: assert property (p_slow_keep) else $error("slow mode oscillator keep wrong"); // R04
    property p_fast_on;
        @(posedge clk) disable iff (sys_rst)
        mode_r == MD_FAST |-> fast_osc_run && sub_clk_on && slow_osc_run && cpu_run;
    endproperty
    a_fast_on: assert property (p_fast_on) else $error("fast mode clocks wrong"); // R03

endmodule

// ---- dv/tb_scmc_top.sv ----
`timescale 1ns/1ps
module tb_scmc_top;
    import scmc_pkg::*;

    // One power-down case: source, keep bits, watchdog, expected mode and clock states
    typedef struct {
        logic       sub;
        logic       fh;
        logic       fs;
        logic       wdt;
        scmc_mode_e mode;
        logic       sys_on;
        logic       sub_on;
        logic       frun;
    } scmc_halt_case_s;

    logic            clk;
    logic            sys_rst;
    logic            clk_en;
    logic [7:0]      reg_addr;
    logic [7:0]      reg_wdata;
    logic            reg_wr;
    logic            reg_rd;
    logic [7:0]      reg_rdata;
    logic            halt_exec;
    logic            wake_event;
    logic            clr_wdt_exec;
    logic            wdt_timeout;
    logic            wdt_enable;
    logic            fast_osc_tick;
    logic            slow_osc_tick;
    logic            slow_osc_stable;
    logic            fast_osc_run;
    logic            slow_osc_run;
    logic            cpu_run;
    logic            sys_clk_tick;
    logic            sys_clk_on;
    logic            sys_on_slow;
    logic            fast_clk_on;
    logic            sub_clk_on;
    logic [6:0]      fast_div_tick;
    logic            power_down_flag;
    logic            watchdog_timeout_flag;
    logic [5:0]      op_mode;
    logic [3:0]      tick_cnt;
    logic [7:0]      rd;
    int              cnt;
    int              mismatches;
    int              total_checks;
    scmc_halt_case_s tab [7];
    scmc_halt_case_s c;

    scmc_top dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec), .wake_event(wake_event),
        .clr_wdt_exec(clr_wdt_exec), .wdt_timeout(wdt_timeout), .wdt_enable(wdt_enable),
        .fast_osc_tick(fast_osc_tick), .slow_osc_tick(slow_osc_tick), .slow_osc_stable(slow_osc_stable),
        .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run), .cpu_run(cpu_run), .sys_clk_tick(sys_clk_tick),
        .sys_clk_on(sys_clk_on), .sys_on_slow(sys_on_slow), .fast_clk_on(fast_clk_on), .sub_clk_on(sub_clk_on),
        .fast_div_tick(fast_div_tick), .power_down_flag(power_down_flag),
        .watchdog_timeout_flag(watchdog_timeout_flag), .op_mode(op_mode));

    always #10 clk = ~clk;

    // Oscillator models: a stopped oscillator gives no ticks, so restarts really take time
    always @(posedge clk) begin
        tick_cnt      <= tick_cnt + 4'h1;
        fast_osc_tick <= fast_osc_run & ~tick_cnt[0];
        slow_osc_tick <= slow_osc_run & (tick_cnt == 4'hf);
    end

    task automatic print_verdict;
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bus tasks start just after an edge; the idle edge at the end avoids double strobe assignment
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask

    // One-cycle pulse: 0 halt, 1 wake, 2 clear watchdog, 3 watchdog timeout
    task automatic pulse(input int w);
        case (w)
            0: halt_exec <= 1'b1;
            1: wake_event <= 1'b1;
            2: clr_wdt_exec <= 1'b1;
            default: wdt_timeout <= 1'b1;
        endcase
        @(posedge clk);
        halt_exec    <= 1'b0;
        wake_event   <= 1'b0;
        clr_wdt_exec <= 1'b0;
        wdt_timeout  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_mode(input logic [5:0] m);
        for (int i = 0; i < 8000; i++) begin
            @(posedge clk);
            #1;
            if (op_mode === m) begin
                @(posedge clk);
                return;
            end
        end
        mismatches++;
        $display("ERROR op_mode expected %h seen %h", m, op_mode);
        print_verdict();
    endtask

    task automatic poll_stable;
        for (int i = 0; i < 4000; i++) begin
            reg_read(SCMC_FAST_OSC_CONTROL_ADDR, rd);
            if (rd[SCMC_STABLE_BIT] === 1'b1) return;
        end
        mismatches++;
        $display("ERROR stable flag expected 1 seen %h", rd);
        print_verdict();
    endtask

    // Window length is a multiple of every tick period, so the count is phase independent
    task automatic count_ticks(output int n);
        n = 0;
        repeat (1024) begin
            @(posedge clk);
            #1;
            if (sys_clk_tick === 1'b1) n++;
        end
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        halt_exec = 1'b0;
        wake_event = 1'b0;
        clr_wdt_exec = 1'b0;
        wdt_timeout = 1'b0;
        wdt_enable = 1'b0;
        fast_osc_tick = 1'b0;
        slow_osc_tick = 1'b0;
        slow_osc_stable = 1'b0;
        tick_cnt = 4'h0;
        mismatches = 0;
        total_checks = 0;
        tab = '{'{1'b0, 1'b0, 1'b0, 1'b0, MD_SLEEP, 1'b0, 1'b0, 1'b0},
                '{1'b0, 1'b0, 1'b0, 1'b1, MD_SLEEP, 1'b0, 1'b0, 1'b0},
                '{1'b0, 1'b0, 1'b1, 1'b0, MD_IDLE_SLOW_ONLY, 1'b0, 1'b1, 1'b0},
                '{1'b0, 1'b1, 1'b1, 1'b0, MD_IDLE_BOTH_CLOCKS, 1'b1, 1'b1, 1'b1},
                '{1'b0, 1'b1, 1'b0, 1'b0, MD_IDLE_FAST_ONLY, 1'b1, 1'b0, 1'b1},
                '{1'b1, 1'b0, 1'b1, 1'b0, MD_IDLE_SLOW_ONLY, 1'b1, 1'b1, 1'b0},
                '{1'b1, 1'b1, 1'b0, 1'b0, MD_IDLE_FAST_ONLY, 1'b0, 1'b0, 1'b1}};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // Reset values and an unmapped place
        reg_read(SCMC_SYS_CLOCK_CONTROL_ADDR, rd);
        check("sys ctrl reset", 16'(rd), 16'h0000);
        reg_read(SCMC_FAST_OSC_CONTROL_ADDR, rd);
        check("osc ctrl reset", 16'(rd), 16'h0001);
        reg_read(8'h05, rd);
        check("unmapped read", 16'(rd), 16'h0000);
        check("op_mode reset", 16'(op_mode), 16'(MD_FAST));
        poll_stable();
        check("fast_clk_on", 16'(fast_clk_on), 16'h0001);
        // Every fast division: tick count halves per code step
        for (int k = 0; k < 7; k++) begin
            reg_write(SCMC_SYS_CLOCK_CONTROL_ADDR, {3'(k), 5'h00});
            repeat (300) @(posedge clk);
            count_ticks(cnt);
            check("fast div ticks", 16'(cnt), 16'(512 >> k));
        end
        // Unimplemented and read-only bits, frozen clock enable, unmapped write
        reg_write(SCMC_SYS_CLOCK_CONTROL_ADDR, 8'h1f);
        reg_read(SCMC_SYS_CLOCK_CONTROL_ADDR, rd);
        check("sys ctrl mask", 16'(rd), 16'h0003);
        reg_write(SCMC_FAST_OSC_CONTROL_ADDR, 8'hfd);
        reg_read(SCMC_FAST_OSC_CONTROL_ADDR, rd);
        check("osc ctrl mask", 16'(rd), 16'h0003);
        clk_en <= 1'b0;
        reg_write(SCMC_SYS_CLOCK_CONTROL_ADDR, 8'h00);
        clk_en <= 1'b1;
        reg_write(8'h07, 8'hff);
        reg_read(SCMC_SYS_CLOCK_CONTROL_ADDR, rd);
        check("sys ctrl held", 16'(rd), 16'h0003);
        // Switch to sub clock waits for the slow oscillator
        reg_write(SCMC_SYS_CLOCK_CONTROL_ADDR, {SCMC_SEL_SUB, 5'h00});
        repeat (100) @(posedge clk);
        check("mode before slow stable", 16'(op_mode), 16'(MD_FAST));
        slow_osc_stable <= 1'b1;
        wait_mode(MD_SLOW);
        check("sys_on_slow", 16'(sys_on_slow), 16'h0001);
        count_ticks(cnt);
        check("sub ticks", 16'(cnt), 16'h0040);
        // In SLOW the enable bit governs the fast oscillator
        reg_write(SCMC_FAST_OSC_CONTROL_ADDR, 8'h00);
        check("fast run off", 16'(fast_osc_run), 16'h0000);
        reg_read(SCMC_FAST_OSC_CONTROL_ADDR, rd);
        check("osc ctrl off", 16'(rd), 16'h0000);
        reg_write(SCMC_FAST_OSC_CONTROL_ADDR, 8'h01);
        check("fast run on", 16'(fast_osc_run), 16'h0001);
        reg_read(SCMC_FAST_OSC_CONTROL_ADDR, rd);
        check("stable cleared", 16'(rd), 16'h0001);
        poll_stable();
        // Fast code in SLOW with the oscillator stopped forces a restart
        reg_write(SCMC_FAST_OSC_CONTROL_ADDR, 8'h00);
        reg_write(SCMC_SYS_CLOCK_CONTROL_ADDR, 8'h00);
        #1 check("restart run", 16'(fast_osc_run), 16'h0001);
        check("mode during restart", 16'(op_mode), 16'(MD_SLOW));
        check("fast_clk_on restart", 16'(fast_clk_on), 16'h0000);
        @(posedge clk);
        wait_mode(MD_FAST);
        reg_read(SCMC_FAST_OSC_CONTROL_ADDR, rd);
        check("stable after restart", 16'(rd), 16'h0002);
        // Every power-down mode, each entered from a set timeout flag
        for (int i = 0; i < 7; i++) begin
            c = tab[i];
            wdt_enable <= c.wdt;
            reg_write(SCMC_SYS_CLOCK_CONTROL_ADDR, {c.sub ? SCMC_SEL_SUB : 3'h0, 3'h0, c.fh, c.fs});
            wait_mode(c.sub ? MD_SLOW : MD_FAST);
            pulse(3);
            pulse(0);
            #1 check("halt mode", 16'(op_mode), 16'(c.mode));
            check("cpu_run", 16'(cpu_run), 16'h0000);
            check("power_down_flag", 16'(power_down_flag), 16'h0001);
            check("timeout flag", 16'(watchdog_timeout_flag), 16'h0000);
            check("sys_clk_on", 16'(sys_clk_on), 16'(c.sys_on));
            check("sub_clk_on", 16'(sub_clk_on), 16'(c.sub_on));
            check("fast_osc_run", 16'(fast_osc_run), 16'(c.frun));
            check("slow_osc_run", 16'(slow_osc_run), 16'((c.mode != MD_SLEEP) | c.wdt));
            @(posedge clk);
            pulse(1);
            wait_mode(c.sub ? MD_SLOW : MD_FAST);
            pulse(2);
            #1 check("flag cleared", 16'(power_down_flag), 16'h0000);
            @(posedge clk);
        end
        print_verdict();
    end
endmodule
